// ---- core/skip_rot_pkg.sv ----
`default_nettype none
package skip_rot_pkg;
   // ************************************************************
   // Register map (byte addresses, one aligned word each)
   // ************************************************************
   localparam logic [3:0] OPERAND_OFS = 4'h0;
   localparam logic [3:0] PSW_OFS     = 4'h4;
   localparam logic [3:0] COMMAND_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS  = 4'hc;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int MEM_LSB   = 0;
   localparam int IMM_LSB   = 4;
   localparam int GREG_LSB  = 8;
   localparam int OP_LSB    = 0;
   localparam logic [3:0] PSW_RST  = 4'h0;
   localparam logic [3:0] NIB_RST  = 4'h0;

   // ************************************************************
   // Command codes written to the command register
   // ************************************************************
   localparam logic [2:0] OP_NOP                  = 3'h0;
   localparam logic [2:0] OP_SKIP_IF_EQUAL        = 3'h1;
   localparam logic [2:0] OP_SKIP_IF_NOT_EQUAL    = 3'h2;
   localparam logic [2:0] OP_SKIP_IF_GREATER_EQ   = 3'h3;
   localparam logic [2:0] OP_SKIP_IF_LESS         = 3'h4;
   localparam logic [2:0] OP_ROTATE_RIGHT_REG     = 3'h5;
   localparam logic [2:0] OP_ADD_WITH_CARRY_REG   = 3'h6;
   localparam logic [2:0] OP_ROTATE_RIGHT_MEM     = 3'h7;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic bcd;
      logic compare_only_flag;
      logic zero;
      logic carry_flag;
   } program_status_word_t;

   typedef struct packed {
      logic [3:0] gen_reg;
      logic [3:0] imm;
      logic [3:0] mem;
   } operand_t;

   typedef struct packed {
      logic                 skip;
      logic                 reg_we;
      logic [3:0]           new_reg;
      program_status_word_t new_psw;
      logic                 illegal;
   } exec_res_t;
endpackage : skip_rot_pkg
`default_nettype wire

// ---- core/exec_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
module exec_unit
   import skip_rot_pkg::*;
(
   input  wire logic [2:0]           op,
   input  wire operand_t             opd,
   input  wire program_status_word_t psw,
   output exec_res_t                 res
);
   logic [4:0] sum;

   // Decode and evaluate one instruction; flags default to unchanged
   always_comb begin
      res         = '0;
      res.new_psw = psw;
      res.new_reg = opd.gen_reg;
      sum         = 5'h00;
      // Compares never look at the decimal or compare-only flags
      case (op)
         OP_SKIP_IF_EQUAL: begin
            res.skip = (opd.mem == opd.imm);
         end
         OP_SKIP_IF_NOT_EQUAL: begin
            res.skip = (opd.mem != opd.imm);
         end
         OP_SKIP_IF_GREATER_EQ: begin
            res.skip = (opd.mem >= opd.imm);
         end
         OP_SKIP_IF_LESS: begin
            res.skip = (opd.mem < opd.imm);
         end
         OP_ROTATE_RIGHT_REG: begin
            // Written back even in compare-only mode, zero kept
            res.reg_we             = 1'b1;
            res.new_reg            = {psw.carry_flag,
                                      opd.gen_reg[3:1]};
            res.new_psw.carry_flag = opd.gen_reg[0];
         end
         OP_ADD_WITH_CARRY_REG: begin
            // Register plus itself plus carry is a left rotate
            sum = {1'b0, opd.gen_reg} + {1'b0, opd.gen_reg}
                  + {4'h0, psw.carry_flag};
            res.reg_we             = ~psw.compare_only_flag;
            res.new_reg            = sum[3:0];
            res.new_psw.carry_flag = sum[4];
            res.new_psw.zero       = psw.zero & (sum[3:0] == 4'h0);
         end
         OP_ROTATE_RIGHT_MEM: begin
            res.illegal = 1'b1;
         end
         default: begin
            res.skip = 1'b0;
         end
      endcase
   end
endmodule : exec_unit
`default_nettype wire

// ---- core/skip_compare_rotate_unit.sv ----
// Behaviour
// - Equal compare of memory nibble and immediate skips next instruction on match.
// - Not-equal compare skips the next instruction when nibble and immediate differ.
// - Greater-or-equal compare skips when nibble is at least the immediate.
// - Less compare skips only when nibble is strictly below the immediate.
// - Rotate right works on the general register only; memory target refused.
// - Rotate right ignores decimal and compare-only flags, keeps zero flag.
// - Rotate right loads old carry into bit 3, shifts others downward.
// - Rotate right puts the bit leaving bit 0 into carry.
// - Add-with-carry of register to itself gives rotate left through carry outside compare-only mode.
// - Compares ignore decimal and compare-only flags, leave carry and zero.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module skip_compare_rotate_unit
   import skip_rot_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             skip_next,
   output logic      [3:0]  gen_reg,
   output logic             carry_flag
);
   // ************************************************************
   // Bus address phase capture
   // ************************************************************
   logic                 a_wr_r, a_wr_nxt;
   logic [3:0]           a_ofs_r, a_ofs_nxt;
   logic                 a_hit;

   // Only word transfers are meaningful; size is not checked
   assign a_hit = hsel & htrans[1] & hready;

   // Latch the address phase for the following data phase
   always_comb begin
      a_wr_nxt  = a_hit & hwrite;
      a_ofs_nxt = a_hit ? haddr[3:0] : 4'h0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_wr_r  <= 1'b0;
         a_ofs_r <= 4'h0;
      end else begin
         a_wr_r  <= a_wr_nxt;
         a_ofs_r <= a_ofs_nxt;
      end
   end

   // ************************************************************
   // Instruction issue and execution
   // ************************************************************
   operand_t             opd_r, opd_nxt;
   program_status_word_t psw_r, psw_nxt;
   logic                 skip_r, skip_nxt;
   logic                 squash_r, squash_nxt;
   logic                 illegal_r, illegal_nxt;
   logic                 cmd_wr;
   logic                 exec_w;
   logic [2:0]           exec_op;
   exec_res_t            res;

   assign cmd_wr  = a_wr_r & (a_ofs_r == COMMAND_OFS);
   assign exec_op = hwdata[OP_LSB +: 3];
   // A command arriving while a skip is pending is the skipped one
   assign exec_w  = cmd_wr & ~skip_r;

   exec_unit u_exec (
      .op  (exec_op),
      .opd (opd_r),
      .psw (psw_r),
      .res (res)
   );

   // Next state of operands, flags and skip bookkeeping
   always_comb begin
      opd_nxt     = opd_r;
      psw_nxt     = psw_r;
      skip_nxt    = skip_r;
      squash_nxt  = squash_r;
      illegal_nxt = illegal_r;
      if (a_wr_r && a_ofs_r == OPERAND_OFS) begin
         opd_nxt = hwdata[11:0];
      end
      if (a_wr_r && a_ofs_r == PSW_OFS) begin
         psw_nxt = hwdata[3:0];
      end
      if (cmd_wr && skip_r) begin
         // Fetched but thrown away: no register or flag change
         skip_nxt   = 1'b0;
         squash_nxt = 1'b1;
      end else if (exec_w) begin
         skip_nxt    = res.skip;
         squash_nxt  = 1'b0;
         illegal_nxt = res.illegal;
         psw_nxt     = res.new_psw;
         if (res.reg_we) begin
            opd_nxt.gen_reg = res.new_reg;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opd_r     <= {NIB_RST, NIB_RST, NIB_RST};
         psw_r     <= PSW_RST;
         skip_r    <= 1'b0;
         squash_r  <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         opd_r     <= opd_nxt;
         psw_r     <= psw_nxt;
         skip_r    <= skip_nxt;
         squash_r  <= squash_nxt;
         illegal_r <= illegal_nxt;
      end
   end

   // ************************************************************
   // Read data and outputs
   // ************************************************************
   logic [31:0] rdata_r, rdata_nxt;

   // Reads use next values so a write just before is seen
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (a_hit && !hwrite) begin
         case (haddr[3:0])
            OPERAND_OFS: rdata_nxt = {20'h00000, opd_nxt};
            PSW_OFS:     rdata_nxt = {28'h0000000, psw_nxt};
            STATUS_OFS:  rdata_nxt = {29'h00000000, illegal_nxt,
                                      squash_nxt, skip_nxt};
            default:     rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r    <= 32'h0000_0000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         skip_next  <= 1'b0;
         gen_reg    <= 4'h0;
         carry_flag <= 1'b0;
      end else begin
         rdata_r    <= rdata_nxt;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         skip_next  <= skip_nxt;
         gen_reg    <= opd_nxt.gen_reg;
         carry_flag <= psw_nxt.carry_flag;
      end
   end

   assign hrdata = rdata_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic eq_w, lt_w, is_cmp;
   assign eq_w   = (opd_r.mem == opd_r.imm);
   assign lt_w   = (opd_r.mem < opd_r.imm);
   assign is_cmp = (exec_op >= OP_SKIP_IF_EQUAL) &&
                   (exec_op <= OP_SKIP_IF_LESS);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   equal_skip_a: assert property (
      exec_w && exec_op == OP_SKIP_IF_EQUAL |=> skip_r == $past(eq_w))
      else $error("equal compare skip wrong");
   noteq_skip_a: assert property (
      exec_w && exec_op == OP_SKIP_IF_NOT_EQUAL |=> skip_r != $past(eq_w))
      else $error("not-equal compare skip wrong");
   gteq_skip_a: assert property (
      exec_w && exec_op == OP_SKIP_IF_GREATER_EQ |=> skip_r == !$past(lt_w))
      else $error("greater-equal compare skip wrong");
   less_skip_a: assert property (
      exec_w && exec_op == OP_SKIP_IF_LESS |=> skip_r == $past(lt_w))
      else $error("less compare skip wrong");
   mem_rotate_a: assert property (
      exec_w && exec_op == OP_ROTATE_RIGHT_MEM
      |=> illegal_r && $stable(opd_r) && $stable(psw_r))
      else $error("memory rotate not refused");
   rotr_flags_a: assert property (
      exec_w && exec_op == OP_ROTATE_RIGHT_REG
      |=> psw_r.zero == $past(psw_r.zero) &&
          skip_next == 1'b0 && gen_reg == opd_r.gen_reg)
      else $error("rotate right flag handling wrong");
   rotr_data_a: assert property (
      exec_w && exec_op == OP_ROTATE_RIGHT_REG
      |=> opd_r.gen_reg == {$past(psw_r.carry_flag),
                            $past(opd_r.gen_reg[3:1])})
      else $error("rotate right data wrong");
   rotr_carry_a: assert property (
      exec_w && exec_op == OP_ROTATE_RIGHT_REG
      |=> psw_r.carry_flag == $past(opd_r.gen_reg[0]) ##1
          carry_flag == psw_r.carry_flag || a_wr_r)
      else $error("rotate right carry wrong");
   rotl_add_with_carry_a: assert property (
      exec_w && exec_op == OP_ADD_WITH_CARRY_REG &&
      !psw_r.compare_only_flag
      |=> {psw_r.carry_flag, opd_r.gen_reg} ==
          {$past(opd_r.gen_reg), $past(psw_r.carry_flag)})
      else $error("add-with-carry rotate left wrong");
   cmp_flags_a: assert property (
      exec_w && is_cmp |=> $stable(psw_r) && $stable(opd_r))
      else $error("compare changed flags or register");
   discard_a: assert property (
      cmd_wr && skip_r
      |=> !skip_r && squash_r && $stable(opd_r) && $stable(psw_r))
      else $error("skipped instruction not discarded");

   skip_taken_c:  cover property (exec_w && is_cmp ##1 skip_r ##[1:20] cmd_wr);
   rotr_chain_c:  cover property (exec_w && exec_op == OP_ROTATE_RIGHT_REG
                                  ##[1:20] exec_w &&
                                  exec_op == OP_ROTATE_RIGHT_REG);
   rotl_c:        cover property (exec_w && exec_op == OP_ADD_WITH_CARRY_REG);
   refused_c:     cover property (exec_w && exec_op == OP_ROTATE_RIGHT_MEM);
endmodule : skip_compare_rotate_unit
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
   import skip_rot_pkg::*;
;
   // ************************************************************
   // Bench signals
   // ************************************************************
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        skip_next;
   logic [3:0]  gen_reg;
   logic        carry_flag;
   int          err_count;
   int          n_tests;

   // Single slave: its ready is the bus ready
   skip_compare_rotate_unit dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .skip_next(skip_next),
      .gen_reg(gen_reg), .carry_flag(carry_flag));

   // Free-running 40 MHz clock
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One single transfer; waits on ready, no fixed latency assumed
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {28'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      #1;
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] r);
      bus(a, 1'b0, 32'h0, r);
   endtask : rd

   // Skip outcome of each compare, operands unsigned
   function automatic logic exp_skip(input logic [2:0] op,
                                     input logic [3:0] m, input logic [3:0] i);
      case (op)
         OP_SKIP_IF_EQUAL:      return m == i;
         OP_SKIP_IF_NOT_EQUAL:  return m != i;
         OP_SKIP_IF_GREATER_EQ: return m >= i;
         default:               return m < i;
      endcase
   endfunction : exp_skip

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_reset;
      logic [31:0] v;
      check(32'({hresp, skip_next, gen_reg, carry_flag}), 32'h0);
      check(32'(hready), 32'h1);
      rd(OPERAND_OFS, v);
      check(v, 32'h0);
      rd(PSW_OFS, v);
      check(v, 32'h0);
      rd(STATUS_OFS, v);
      check(v, 32'h0);
      $display("test reset done");
   endtask : test_reset

   // Every compare op over all operand pairs, each followed by a rotate that
   // must be discarded exactly when a skip was pending
   task automatic test_compare;
      logic [31:0] v;
      logic [2:0]  op;
      logic [3:0]  m;
      logic [3:0]  i;
      logic [3:0]  p;
      logic [3:0]  g;
      logic        s;
      for (int k = 0; k < 4; k++) begin
         for (int n = 0; n < 256; n++) begin
            op = OP_SKIP_IF_EQUAL + 3'(k);
            m = n[3:0];
            i = n[7:4];
            p = i ^ {m[1:0], m[3:2]};
            g = m ^ 4'h5;
            s = exp_skip(op, m, i);
            wr(PSW_OFS, {28'h0, p});
            wr(OPERAND_OFS, {20'h0, g, i, m});
            wr(COMMAND_OFS, {29'h0, op});
            check(32'(skip_next), 32'(s));
            check(32'({gen_reg, carry_flag}), 32'({g, p[0]}));
            wr(COMMAND_OFS, {29'h0, OP_ROTATE_RIGHT_REG});
            rd(STATUS_OFS, v);
            if (s) begin
               check(32'({gen_reg, carry_flag, v[2:0]}), 32'({g, p[0], 3'h2}));
            end else begin
               check(32'({gen_reg, carry_flag, v[2:0]}), 32'({p[0], g, 3'h0}));
            end
            rd(PSW_OFS, v);
            check(v, 32'({p[3:1], s ? p[0] : g[0]}));
         end
      end
      $display("test compare done");
   endtask : test_compare

   task automatic test_rotate_left;
      logic [31:0] v;
      logic [4:0]  sum;
      logic [3:0]  g;
      logic        c;
      logic        cm;
      for (int n = 0; n < 64; n++) begin
         g = n[3:0];
         c = n[4];
         cm = n[5];
         sum = 5'(g) + 5'(g) + 5'(c);
         wr(PSW_OFS, 32'({1'b0, cm, 1'b1, c}));
         wr(OPERAND_OFS, {20'h0, g, 8'h0});
         wr(COMMAND_OFS, {29'h0, OP_ADD_WITH_CARRY_REG});
         rd(PSW_OFS, v);
         check(v, 32'({cm, sum[3:0] == 4'h0, sum[4]}));
         check(32'(gen_reg), 32'(cm ? g : sum[3:0]));
      end
      $display("test rotate left done");
   endtask : test_rotate_left

   // Memory-target rotate refused; read-only and write-only places
   task automatic test_refuse;
      logic [31:0] v;
      wr(PSW_OFS, 32'h1);
      wr(OPERAND_OFS, 32'h900);
      wr(COMMAND_OFS, {29'h0, OP_ROTATE_RIGHT_MEM});
      rd(STATUS_OFS, v);
      check(32'({gen_reg, carry_flag, v[2:0]}), 32'h9c);
      wr(STATUS_OFS, 32'h7);
      rd(STATUS_OFS, v);
      check(v, 32'h4);
      rd(COMMAND_OFS, v);
      check(v, 32'h0);
      rd(OPERAND_OFS, v);
      check(v, 32'h900);
      // Bus stays ready with an OKAY response even after a refusal
      check(32'({hready, hresp}), 32'h2);
      $display("test refuse done");
   endtask : test_refuse

   // ************************************************************
   // Verdict and run control
   // ************************************************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // Whole run is about 19k cycles; cut off well beyond that
   initial begin
      #2000000;
      err_count++;
      test_done();
   end

   initial begin
      err_count = 0;
      n_tests = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      test_reset();
      test_compare();
      test_rotate_left();
      test_refuse();
      test_done();
   end
endmodule : tb
`default_nettype wire
